// *** rtl/sdci_fifo.v ***
`timescale 1ns/1ns
`default_nettype none

// Small FIFO built from flip-flops with valid/ready on both sides.
module sdci_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             arst_n,
  // Filling side.
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side.
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ff;
  reg [AW-1:0]    rd_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;
  integer         i;

  // Full and empty follow the occupancy count.
  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers wrap at the depth, so the depth need not be a power of two.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_ff[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_ff[wr_ff] <= in_data;
        wr_ff         <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/sdci_regs.vh ***
`ifndef SDCI_REGS_VH
`define SDCI_REGS_VH

// Frame characters for ASCII mode.
`define SDCI_CHR_COLON   8'h3A
`define SDCI_CHR_CR      8'h0D
`define SDCI_CHR_LF      8'h0A
`define SDCI_CHR_ZERO    8'h30
`define SDCI_CHR_ALPHA   8'h37

// Operation codes.
`define SDCI_OP_PRD      8'h01
`define SDCI_OP_PWR      8'h02
`define SDCI_OP_CTRL     8'h03
`define SDCI_OP_STAT     8'h04
`define SDCI_ERR_FLAG    8'h80
`define SDCI_ERR_PARAM   8'h81
`define SDCI_ERR_CTRL    8'h83
`define SDCI_ERR_STAT    8'h84

// Payload length values.
`define SDCI_LEN_WORD    8'h03
`define SDCI_LEN_BYTE    8'h02
`define SDCI_LEN_ERR     8'h01

// Station address range.
`define SDCI_ADDR_BCAST  8'h00
`define SDCI_ADDR_MAX    8'hFA

// Character format selections at and above this value are RTU.
`define SDCI_FMT_RTU     3'h3

// Check values.
`define SDCI_CRC_INIT    16'hFFFF
`define SDCI_CRC_POLY    16'hA001
`define SDCI_LRC_INIT    8'h00

// Receive buffer size in bytes.
`define SDCI_BUF_BYTES   4'h8

// Control command byte bit positions.
`define SDCI_CB_RUN      0
`define SDCI_CB_FWD      1
`define SDCI_CB_REV      2
`define SDCI_CB_STOP     3
`define SDCI_CB_DIRSEL   4
`define SDCI_CB_JOG      5
`define SDCI_CB_JOGF     6
`define SDCI_CB_JOGR     7

// Frame silence time and clock rate.
`define SDCI_QUIET_MS    50
`define SDCI_CLK_KHZ     50000
`define SDCI_QUIET_CYC   (`SDCI_QUIET_MS * `SDCI_CLK_KHZ)

`endif

// *** rtl/sdci_top.v ***
`timescale 1ns/1ns
`default_nettype none
`include "sdci_regs.vh"

// Notes on behaviour
// - Broadcast address zero write or control is applied, never answered.
// - Own nonzero address parameter write is stored and answered.
// - Bad value or unknown parameter answers address, 81H, 01, parameter code.
// - Control byte bits 0..7: run, fwd, rev, stop, dir select, jog, jogf, jogr.
// - Accepted control returns status: run, jog, dir, run, jogging, dir, brake, track.
// - Failed control answers address, 83H, 01, current status byte.
// - Status read code 04 selects one of eight items; broadcast gets nothing.
// - Multi-byte values travel high byte first.
// - Length 3 for a word of data, 2 for a byte or less.
// - ASCII sends each byte as two hex characters; data at most fifty. Here the receive buffer holds 8 bytes, and longer frames are dropped.
// - ASCII check is 100H minus the low byte of the byte sum.
// - RTU frames are delimited by more than 50 ms of line silence.
// - RTU address and operation code are single binary bytes.
// - RTU check register starts at FFFFH.
// - Each byte is XORed into the check register low byte first.
// - Eight right shifts per byte, XOR A001H when a one drops out.
// - RTU check value goes out low byte then high byte.
// - ASCII frame opens with colon and closes with CR then LF.
// - Codes: 01 read, 02 write, 03 control, 04 status, 05, 08; 06-07 reserved; here 05 and 08 get the 80H-plus-code error reply.
// - Station address 1..250 is valid; zero turns communication off.
// - Baud among four rates, eight data bits, one stop, none/even/odd parity.
module sdci_top #(
  parameter [21:0] QUIET_CYC = `SDCI_QUIET_CYC
) (
  // Clock and reset.
  input  wire        CLOCK,
  input  wire        ARST_N,
  // Configuration parameters.
  input  wire [7:0]  STATION_ADDR,
  input  wire [1:0]  BAUD_PARAM,
  input  wire [2:0]  FORMAT_PARAM,
  // Character format to the line UART.
  output reg  [1:0]  BAUD_SEL,
  output reg  [1:0]  PARITY_SEL,
  output reg         RTU_MODE,
  // Received characters.
  input  wire        RX_VALID,
  input  wire [7:0]  RX_DATA,
  // Transmitted characters.
  output reg         TX_VALID,
  output reg  [7:0]  TX_DATA,
  input  wire        TX_READY,
  // Parameter store.
  output reg         PARAM_WR,
  output reg         PARAM_RD,
  output reg  [7:0]  PARAM_CODE,
  output reg  [15:0] PARAM_WDATA,
  input  wire        PARAM_BAD,
  input  wire [15:0] PARAM_RDATA,
  // Drive control commands.
  output reg         CMD_STROBE,
  output reg  [7:0]  CONTROL_COMMAND_BYTE,
  // Drive status.
  input  wire        ST_RUNNING,
  input  wire        ST_JOG,
  input  wire        ST_DIR,
  input  wire        ST_JOGGING,
  input  wire        ST_BRAKING,
  input  wire        ST_TRACK,
  // Status items.
  output reg  [2:0]  ITEM_SEL,
  input  wire [15:0] ITEM_VALUE
);

  localparam [2:0] S_RX   = 3'h0;
  localparam [2:0] S_EXEC = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_SEND = 3'h3;

  reg  [2:0]  st_ff;
  reg  [7:0]  buf_ff [0:7];
  reg  [3:0]  cnt_ff;
  reg  [3:0]  flen_ff;
  reg         ovf_ff;
  reg         fok_ff;
  reg         infr_ff;
  reg         eol_ff;
  reg         hi_ff;
  reg  [3:0]  nib_ff;
  reg  [7:0]  sum_ff;
  reg  [15:0] crc_ff;
  reg  [21:0] idle_ff;
  reg  [7:0]  rep_ff [0:5];
  reg  [2:0]  rn_ff;
  reg  [4:0]  sq_ff;
  reg  [7:0]  tsum_ff;
  reg  [15:0] tcrc_ff;
  reg  [7:0]  chr;
  reg         last;
  reg  [7:0]  tbyte;
  reg         tdone;
  wire [4:0]  hv;
  wire [7:0]  rx_byte;
  wire [3:0]  nd;
  wire [7:0]  op;
  wire [7:0]  cb;
  wire        bcast;
  wire        mine;
  wire        enabled;
  wire        ctrl_ok;
  wire        stat_ok;
  wire        wr_len_ok;
  wire [7:0]  control_status_byte;
  wire [4:0]  km1;
  wire [4:0]  n2;
  wire [7:0]  lrc;
  wire        f_in_ready;
  wire        f_out_valid;
  wire        f_out_ready;
  wire [7:0]  f_out_data;
  integer     i;

  // One byte of the RTU check: XOR low byte, then eight shifts with polynomial.
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  b;
    integer      k;
    reg   [15:0] r;
    begin
      r = c ^ {8'h00, b};
      for (k = 0; k < 8; k = k + 1) begin
        r = r[0] ? ((r >> 1) ^ `SDCI_CRC_POLY) : (r >> 1);
      end
      crc_step = r;
    end
  endfunction

  // Hex character to nibble; bit 4 flags a legal character.
  function [4:0] hex_val;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39) begin
        hex_val = {1'b1, c[3:0]};
      end else if (c >= 8'h41 && c <= 8'h46) begin
        hex_val = {1'b1, c[3:0] + 4'h9};
      end else begin
        hex_val = 5'h00;
      end
    end
  endfunction

  // Nibble to upper case hex character.
  function [7:0] hex_chr;
    input [3:0] n;
    begin
      hex_chr = (n < 4'hA) ? (`SDCI_CHR_ZERO + {4'h0, n}) : (`SDCI_CHR_ALPHA + {4'h0, n});
    end
  endfunction

  // Decoded view of the stored request.
  assign hv        = hex_val(RX_DATA);
  assign rx_byte   = {nib_ff, hv[3:0]};
  assign nd        = flen_ff - (RTU_MODE ? 4'h5 : 4'h4);
  assign op        = buf_ff[1];
  assign cb        = buf_ff[3];
  assign bcast     = (buf_ff[0] == `SDCI_ADDR_BCAST);
  assign mine      = (buf_ff[0] == STATION_ADDR);
  assign enabled   = (STATION_ADDR != `SDCI_ADDR_BCAST) && (STATION_ADDR <= `SDCI_ADDR_MAX);
  assign wr_len_ok = (nd == 4'h2) || (nd == 4'h3);
  assign ctrl_ok   = (nd == 4'h1) && !(cb[`SDCI_CB_FWD] && cb[`SDCI_CB_REV])
                     && !(cb[`SDCI_CB_JOGF] && cb[`SDCI_CB_JOGR]);
  assign stat_ok   = (nd == 4'h1) && (cb[7:3] == 5'h00);
  // Status byte repeats running and direction in two places each.
  assign control_status_byte      = {ST_TRACK, ST_BRAKING, ST_DIR, ST_JOGGING,
                      ST_RUNNING, ST_DIR, ST_JOG, ST_RUNNING};

  // Character format follows the configuration parameters.
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      BAUD_SEL   <= 2'h1;
      PARITY_SEL <= 2'h0;
      RTU_MODE   <= 1'b0;
    end else begin
      BAUD_SEL   <= BAUD_PARAM;
      RTU_MODE   <= (FORMAT_PARAM >= `SDCI_FMT_RTU);
      PARITY_SEL <= FORMAT_PARAM[1:0] - ((FORMAT_PARAM >= `SDCI_FMT_RTU) ? 2'h3 : 2'h0);
    end
  end

  // Receive framing, request execution and reply sequencing.
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff       <= S_RX;
      cnt_ff      <= 4'h0;
      flen_ff     <= 4'h0;
      ovf_ff      <= 1'b0;
      fok_ff      <= 1'b0;
      infr_ff     <= 1'b0;
      eol_ff      <= 1'b0;
      hi_ff       <= 1'b0;
      nib_ff      <= 4'h0;
      sum_ff      <= `SDCI_LRC_INIT;
      crc_ff      <= `SDCI_CRC_INIT;
      idle_ff     <= 22'h00_0000;
      rn_ff       <= 3'h0;
      sq_ff       <= 5'h00;
      tsum_ff     <= `SDCI_LRC_INIT;
      tcrc_ff     <= `SDCI_CRC_INIT;
      PARAM_WR    <= 1'b0;
      PARAM_RD    <= 1'b0;
      PARAM_CODE  <= 8'h00;
      PARAM_WDATA <= 16'h0000;
      CMD_STROBE  <= 1'b0;
      CONTROL_COMMAND_BYTE <= 8'h00;
      ITEM_SEL    <= 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        buf_ff[i] <= 8'h00;
      end
      for (i = 0; i < 6; i = i + 1) begin
        rep_ff[i] <= 8'h00;
      end
    end else begin
      PARAM_WR   <= 1'b0;
      PARAM_RD   <= 1'b0;
      CMD_STROBE <= 1'b0;
      case (st_ff)
        S_RX: begin
          if (RTU_MODE) begin
            infr_ff <= 1'b0;
            if (RX_VALID) begin
              // Binary bytes; address and code are one byte each.
              if (cnt_ff == `SDCI_BUF_BYTES) begin
                ovf_ff <= 1'b1;
              end else begin
                buf_ff[cnt_ff[2:0]] <= RX_DATA;
                cnt_ff <= cnt_ff + 4'h1;
              end
              crc_ff  <= crc_step(crc_ff, RX_DATA);
              idle_ff <= 22'h00_0000;
            end else if (cnt_ff != 4'h0) begin
              if (idle_ff == QUIET_CYC) begin
                // Silence ends the frame; check over data plus CRC leaves zero.
                flen_ff <= cnt_ff;
                fok_ff  <= (crc_ff == 16'h0000) && (cnt_ff >= 4'h5) && !ovf_ff;
                cnt_ff  <= 4'h0;
                ovf_ff  <= 1'b0;
                crc_ff  <= `SDCI_CRC_INIT;
                idle_ff <= 22'h00_0000;
                st_ff   <= S_EXEC;
              end else begin
                idle_ff <= idle_ff + 22'h00_0001;
              end
            end
          end else if (RX_VALID) begin
            if (RX_DATA == `SDCI_CHR_COLON) begin
              // A colon always restarts frame collection.
              infr_ff <= 1'b1;
              cnt_ff  <= 4'h0;
              hi_ff   <= 1'b0;
              eol_ff  <= 1'b0;
              ovf_ff  <= 1'b0;
              sum_ff  <= `SDCI_LRC_INIT;
            end else if (infr_ff) begin
              if (eol_ff) begin
                infr_ff <= 1'b0;
                if (RX_DATA == `SDCI_CHR_LF && !hi_ff) begin
                  // Sum including the check byte is zero when the check holds.
                  flen_ff <= cnt_ff;
                  fok_ff  <= (sum_ff == 8'h00) && (cnt_ff >= 4'h4) && !ovf_ff;
                  st_ff   <= S_EXEC;
                end
              end else if (RX_DATA == `SDCI_CHR_CR) begin
                eol_ff <= 1'b1;
              end else if (!hv[4]) begin
                infr_ff <= 1'b0;
              end else if (!hi_ff) begin
                nib_ff <= hv[3:0];
                hi_ff  <= 1'b1;
              end else begin
                hi_ff  <= 1'b0;
                sum_ff <= sum_ff + rx_byte;
                if (cnt_ff == `SDCI_BUF_BYTES) begin
                  ovf_ff <= 1'b1;
                end else begin
                  buf_ff[cnt_ff[2:0]] <= rx_byte;
                  cnt_ff <= cnt_ff + 4'h1;
                end
              end
            end
          end
        end
        S_EXEC: begin
          // Foreign address, bad check, overflow or disabled station: drop.
          if (!enabled || !fok_ff || !(bcast || mine)) begin
            st_ff <= S_RX;
          end else begin
            st_ff <= S_WAIT;
            case (op)
              `SDCI_OP_PWR: begin
                PARAM_WR    <= wr_len_ok;
                PARAM_CODE  <= buf_ff[3];
                PARAM_WDATA <= (nd == 4'h3) ? {buf_ff[4], buf_ff[5]} : {8'h00, buf_ff[4]};
              end
              `SDCI_OP_PRD: begin
                PARAM_RD   <= (nd == 4'h1) && !bcast;
                PARAM_CODE <= buf_ff[3];
              end
              `SDCI_OP_CTRL: begin
                if (ctrl_ok) begin
                  CMD_STROBE           <= 1'b1;
                  CONTROL_COMMAND_BYTE <= cb;
                end
              end
              `SDCI_OP_STAT: begin
                ITEM_SEL <= cb[2:0];
              end
              default: begin
                ITEM_SEL <= ITEM_SEL;
              end
            endcase
          end
        end
        S_WAIT: begin
          // Store and drive answers are sampled one cycle after the strobe.
          rep_ff[0] <= buf_ff[0];
          rep_ff[3] <= buf_ff[3];
          rep_ff[4] <= 8'h00;
          rep_ff[5] <= 8'h00;
          rn_ff     <= 3'h4;
          case (op)
            `SDCI_OP_PWR: begin
              if (PARAM_BAD || !wr_len_ok) begin
                rep_ff[1] <= `SDCI_ERR_PARAM;
                rep_ff[2] <= `SDCI_LEN_ERR;
              end else begin
                rep_ff[1] <= op;
                rep_ff[2] <= (nd == 4'h3) ? `SDCI_LEN_WORD : `SDCI_LEN_BYTE;
                rep_ff[4] <= buf_ff[4];
                rep_ff[5] <= buf_ff[5];
                rn_ff     <= nd[2:0] + 3'h3;
              end
            end
            `SDCI_OP_PRD: begin
              if (PARAM_BAD || nd != 4'h1) begin
                rep_ff[1] <= `SDCI_ERR_PARAM;
                rep_ff[2] <= `SDCI_LEN_ERR;
              end else begin
                rep_ff[1] <= op;
                rep_ff[2] <= `SDCI_LEN_WORD;
                rep_ff[4] <= PARAM_RDATA[15:8];
                rep_ff[5] <= PARAM_RDATA[7:0];
                rn_ff     <= 3'h6;
              end
            end
            `SDCI_OP_CTRL: begin
              rep_ff[1] <= ctrl_ok ? op : `SDCI_ERR_CTRL;
              rep_ff[2] <= ctrl_ok ? `SDCI_LEN_BYTE : `SDCI_LEN_ERR;
              rep_ff[3] <= control_status_byte;
            end
            `SDCI_OP_STAT: begin
              rep_ff[1] <= stat_ok ? op : `SDCI_ERR_STAT;
              rep_ff[2] <= stat_ok ? `SDCI_LEN_WORD : `SDCI_LEN_ERR;
              rep_ff[3] <= stat_ok ? ITEM_VALUE[15:8] : cb;
              rep_ff[4] <= ITEM_VALUE[7:0];
              rn_ff     <= stat_ok ? 3'h5 : 3'h4;
            end
            default: begin
              rep_ff[1] <= `SDCI_ERR_FLAG | op;
              rep_ff[2] <= `SDCI_LEN_ERR;
              rep_ff[3] <= op;
            end
          endcase
          sq_ff   <= 5'h00;
          tsum_ff <= `SDCI_LRC_INIT;
          tcrc_ff <= `SDCI_CRC_INIT;
          st_ff   <= bcast ? S_RX : S_SEND;
        end
        S_SEND: begin
          // One character per accepted push; back-pressure holds the sequence.
          if (f_in_ready) begin
            if (tdone) begin
              tsum_ff <= tsum_ff + tbyte;
              tcrc_ff <= crc_step(tcrc_ff, tbyte);
            end
            sq_ff <= sq_ff + 5'h01;
            if (last) begin
              st_ff <= S_RX;
            end
          end
        end
        default: begin
          st_ff <= S_RX;
        end
      endcase
    end
  end

  // Next reply character from the sequence position.
  assign km1 = sq_ff - 5'h01;
  assign n2  = {1'b0, rn_ff, 1'b0};
  assign lrc = 8'h00 - tsum_ff;
  always @* begin
    chr   = 8'h00;
    last  = 1'b0;
    tbyte = 8'h00;
    tdone = 1'b0;
    if (RTU_MODE) begin
      if (sq_ff < {2'h0, rn_ff}) begin
        tbyte = rep_ff[sq_ff[2:0]];
        tdone = 1'b1;
        chr   = tbyte;
      end else if (sq_ff == {2'h0, rn_ff}) begin
        chr = tcrc_ff[7:0];
      end else begin
        chr  = tcrc_ff[15:8];
        last = 1'b1;
      end
    end else begin
      if (sq_ff == 5'h00) begin
        chr = `SDCI_CHR_COLON;
      end else if (sq_ff <= n2) begin
        tbyte = rep_ff[km1[3:1]];
        tdone = km1[0];
        chr   = hex_chr(km1[0] ? tbyte[3:0] : tbyte[7:4]);
      end else if (sq_ff == n2 + 5'h01) begin
        chr = hex_chr(lrc[7:4]);
      end else if (sq_ff == n2 + 5'h02) begin
        chr = hex_chr(lrc[3:0]);
      end else if (sq_ff == n2 + 5'h03) begin
        chr = `SDCI_CHR_CR;
      end else begin
        chr  = `SDCI_CHR_LF;
        last = 1'b1;
      end
    end
  end

  // Reply characters queue ahead of the line transmitter.
  sdci_fifo #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_fifo (
    .clk       (CLOCK),
    .arst_n    (ARST_N),
    .in_valid  (st_ff == S_SEND),
    .in_ready  (f_in_ready),
    .in_data   (chr),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // Output stage holds each character until the transmitter takes it.
  assign f_out_ready = !TX_VALID || TX_READY;
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_VALID <= 1'b0;
      TX_DATA  <= 8'h00;
    end else if (f_out_ready) begin
      TX_VALID <= f_out_valid;
      TX_DATA  <= f_out_valid ? f_out_data : TX_DATA;
    end
  end

endmodule

`default_nettype wire

// *** sim/sdci_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// Host end of the serial link: sends characters and collects the reply.
module sdci_host (
  input  wire logic       clk,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output var  logic       tx_ready
);
  logic [7:0] got[$];
  logic       slow = 1'b0;
  logic       hold = 1'b0;
  logic [1:0] phase = 2'h0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h55;
    tx_ready = 1'b1;
  end
  // Slow accepts one cycle in four, held none.
  always @(posedge clk) begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    #1;
    tx_ready = !hold && (!slow || phase == 2'h3);
    phase = phase + 2'h1;
  end
  // One character per strobe, then stale data is inverted.
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx_data = b;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_data = ~b;
  endtask
endmodule
`default_nettype wire

// *** sim/sdci_props.sv ***
`timescale 1ns/1ns
`default_nettype none
// Port checks of the interpreter.
module sdci_props (
  input wire logic       CLOCK,
  input wire logic       ARST_N,
  input wire logic [7:0] STATION_ADDR,
  input wire logic [1:0] BAUD_PARAM,
  input wire logic [2:0] FORMAT_PARAM,
  input wire logic [1:0] BAUD_SEL,
  input wire logic       RTU_MODE,
  input wire logic       TX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic       TX_READY,
  input wire logic       CMD_STROBE,
  input wire logic [7:0] CONTROL_COMMAND_BYTE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // A stalled character waits unchanged.
  chk_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("stalled character changed");
  chk_mode_copy: assert property (1 |=> RTU_MODE == ($past(FORMAT_PARAM) >= 3'h3))
    else $error("mode not following format");
  chk_baud_copy: assert property (1 |=> BAUD_SEL == $past(BAUD_PARAM))
    else $error("baud not following setting");
  chk_cmd_legal: assert property (CMD_STROBE |-> !(CONTROL_COMMAND_BYTE[1] &&
    CONTROL_COMMAND_BYTE[2]) && !(CONTROL_COMMAND_BYTE[6] && CONTROL_COMMAND_BYTE[7]))
    else $error("contradictory command was accepted");
  chk_off_silent: assert property ((STATION_ADDR == 8'h00) [*8] |-> !$rose(TX_VALID))
    else $error("reply while switched off");
  chk_ascii_open: assert property ($rose(TX_VALID) && !RTU_MODE |-> TX_DATA == 8'h3A)
    else $error("ASCII reply without colon");
  chk_ascii_char: assert property (TX_VALID && !RTU_MODE |-> TX_DATA inside {8'h3A,
    8'h0D, 8'h0A, [8'h30:8'h39], [8'h41:8'h46]})
    else $error("illegal ASCII reply character");
  chk_cr_lf: assert property (TX_VALID && TX_READY && !RTU_MODE && TX_DATA == 8'h0D
    |-> ##[1:40] (TX_VALID && TX_DATA == 8'h0A))
    else $error("CR without LF");
  // Main scenarios reached.
  cov_cmd: cover property (CMD_STROBE);
  cov_rtu_reply: cover property ($rose(TX_VALID) && RTU_MODE);
  cov_stall: cover property (TX_VALID && !TX_READY);
endmodule
bind sdci_top sdci_props u_props (.CLOCK, .ARST_N, .STATION_ADDR, .BAUD_PARAM, .FORMAT_PARAM,
  .BAUD_SEL, .RTU_MODE, .TX_VALID, .TX_DATA, .TX_READY, .CMD_STROBE, .CONTROL_COMMAND_BYTE);
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", what, exp, got); end end
typedef logic [7:0] sdci_bq_t[$];
module tb_top;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  station = 8'h01;
  logic [2:0]  fmt = 3'h0;
  logic        param_bad = 1'b0;
  logic [5:0]  st = 6'h00;
  wire         rx_valid, tx_valid, tx_ready, param_wr, cmd_strobe;
  wire  [7:0]  rx_data, tx_data, param_code, ccb;
  wire  [15:0] wdata;
  wire  [2:0]  item_sel;
  wire  [1:0]  par;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          n_wr = 0;
  int          n_cmd = 0;
  always #10 clock = ~clock;
  // Counts writes and commands.
  always @(posedge clock) begin
    if (param_wr) n_wr++;
    if (cmd_strobe) n_cmd++;
  end
  sdci_host host (.clk(clock), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  sdci_top #(.QUIET_CYC(22'd20)) DUT (.CLOCK(clock), .ARST_N(arst_n), .STATION_ADDR(station),
    .BAUD_PARAM(2'h2), .FORMAT_PARAM(fmt), .BAUD_SEL(), .PARITY_SEL(par), .RTU_MODE(),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_READY(tx_ready), .PARAM_WR(param_wr), .PARAM_RD(), .PARAM_CODE(param_code),
    .PARAM_WDATA(wdata), .PARAM_BAD(param_bad), .PARAM_RDATA(16'h1234),
    .CMD_STROBE(cmd_strobe), .CONTROL_COMMAND_BYTE(ccb), .ST_RUNNING(st[0]), .ST_JOG(st[1]),
    .ST_DIR(st[2]), .ST_JOGGING(st[3]), .ST_BRAKING(st[4]), .ST_TRACK(st[5]),
    .ITEM_SEL(item_sel), .ITEM_VALUE({5'h02, item_sel, 5'h10, item_sel}));
  function automatic logic [7:0] hex(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // Wraps bytes in the framing of the current mode.
  function automatic sdci_bq_t frame(input sdci_bq_t b);
    sdci_bq_t    f;
    logic [7:0]  lrc;
    logic [15:0] crc;
    lrc = 8'h00;
    crc = 16'hFFFF;
    foreach (b[i]) begin
      lrc += b[i];
      crc ^= {8'h00, b[i]};
      repeat (8) crc = crc[0] ? (crc >> 1) ^ 16'hA001 : crc >> 1;
    end
    if (fmt >= 3'h3) begin
      f = {b, crc[7:0], crc[15:8]};
    end else begin
      b.push_back(8'h00 - lrc);
      f = {8'h3A};
      foreach (b[i]) f = {f, hex(b[i][7:4]), hex(b[i][3:0])};
      f = {f, 8'h0D, 8'h0A};
    end
    return f;
  endfunction
  // Sends a request, maybe with a bad check.
  task automatic request(input sdci_bq_t b, input bit bad = 1'b0);
    sdci_bq_t f;
    f = frame(b);
    if (bad) f[f.size()-3] ^= 8'h01;
    foreach (f[i]) host.send(f[i]);
    if (fmt >= 3'h3) repeat (30) @(posedge clock);
    #1;
  endtask
  // Compares the whole reply.
  task automatic expect_reply(input sdci_bq_t b, input string what);
    sdci_bq_t f;
    f = frame(b);
    for (int t = 0; t < 400 && host.got.size() < f.size(); t++) @(posedge clock);
    repeat (20) @(posedge clock);
    #1;
    `CHK(what, f.size(), host.got.size())
    foreach (f[i]) if (i < host.got.size()) `CHK(what, f[i], host.got[i])
    host.got = {};
  endtask
  task automatic quiet(input string what);
    repeat (80) @(posedge clock);
    #1;
    `CHK(what, 0, host.got.size())
    host.got = {};
  endtask
  // Stalled word write echo, then a refused value.
  task automatic t_write;
    host.hold = 1'b1;
    request('{8'h01, 8'h02, 8'h03, 8'h00, 8'h0B, 8'hB8});
    repeat (100) @(posedge clock);
    host.hold = 1'b0;
    expect_reply('{8'h01, 8'h02, 8'h03, 8'h00, 8'h0B, 8'hB8}, "write echo");
    `CHK("write code", 8'h00, param_code)
    `CHK("write data", 16'h0BB8, wdata)
    `CHK("write count", 1, n_wr)
    param_bad = 1'b1;
    request('{8'h01, 8'h02, 8'h02, 8'h07, 8'h05});
    expect_reply('{8'h01, 8'h81, 8'h01, 8'h07}, "write refused");
    param_bad = 1'b0;
  endtask
  // Quiet broadcast; foreign, corrupt and off frames drop.
  task automatic t_silent;
    int n0;
    n0 = n_wr;
    request('{8'h00, 8'h02, 8'h03, 8'h11, 8'h22, 8'h33});
    quiet("broadcast write");
    `CHK("broadcast stored", n0 + 1, n_wr)
    `CHK("broadcast data", 16'h2233, wdata)
    request('{8'h05, 8'h02, 8'h03, 8'h00, 8'h01, 8'h02});
    quiet("foreign write");
    request('{8'h01, 8'h02, 8'h03, 8'h00, 8'h01, 8'h02}, 1'b1);
    quiet("corrupt check");
    station = 8'h00;
    request('{8'h01, 8'h02, 8'h03, 8'h00, 8'h01, 8'h02});
    quiet("station off");
    station = 8'h01;
    `CHK("dropped not stored", n0 + 1, n_wr)
  endtask
  // Each command bit, then contradictory pairs.
  task automatic t_control;
    logic [7:0] stat;
    logic [7:0] bad[2];
    int         n0;
    bad = '{8'h06, 8'hC0};
    for (int i = 0; i < 8; i++) begin
      st = 6'(i * 11);
      host.slow = i[0];
      stat = {st[5], st[4], st[2], st[3], st[0], st[2], st[1], st[0]};
      request('{8'h01, 8'h03, 8'h02, 8'h01 << i});
      expect_reply('{8'h01, 8'h03, 8'h02, stat}, "control status");
      `CHK("command byte", 8'h01 << i, ccb)
    end
    host.slow = 1'b0;
    request('{8'h00, 8'h03, 8'h02, 8'h01});
    quiet("broadcast control");
    n0 = n_cmd;
    foreach (bad[i]) begin
      request('{8'h01, 8'h03, 8'h02, bad[i]});
      expect_reply('{8'h01, 8'h83, 8'h01, stat}, "control refused");
    end
    `CHK("refused not applied", n0, n_cmd)
  endtask
  // Status selectors, broadcast read, unserved operations.
  task automatic t_status;
    logic [7:0] op[4];
    op = '{8'h05, 8'h06, 8'h07, 8'h08};
    for (int s = 0; s < 8; s++) begin
      request('{8'h01, 8'h04, 8'h01, 8'(s)});
      expect_reply('{8'h01, 8'h04, 8'h03, 8'h10 | 8'(s), 8'h80 | 8'(s)}, "status");
      `CHK("item select", 3'(s), item_sel)
    end
    request('{8'h00, 8'h04, 8'h01, 8'h00});
    quiet("broadcast status");
    foreach (op[i]) begin
      request('{8'h01, op[i], 8'h01, 8'h00});
      expect_reply('{8'h01, 8'h80 | op[i], 8'h01, op[i]}, "other operation");
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog.
  initial begin
    #1_000_000;
    mismatches++;
    results();
  end
  // ASCII scenarios, then RTU.
  initial begin
    repeat (12) @(posedge clock);
    #1;
    arst_n = 1'b1;
    repeat (2) @(posedge clock);
    t_write();
    t_silent();
    t_status();
    fmt = 3'h4;
    repeat (40) @(posedge clock);
    #1;
    `CHK("parity", 2'h1, par)
    t_control();
    t_silent();
    t_status();
    results();
  end
endmodule
`default_nettype wire
